// ==== hdl/nfc_defs.svh ====
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH

// Opcodes
`define NFC_OP_READ 8'h00
`define NFC_OP_RDCONF 8'h30
`define NFC_OP_CBRD 8'h35
`define NFC_OP_MPCACHE 8'h33
`define NFC_OP_RNDOUT 8'h05
`define NFC_OP_RNDOUTC 8'he0
`define NFC_OP_CACHERD 8'h31
`define NFC_OP_CACHEEND 8'h3f
`define NFC_OP_READID 8'h90
`define NFC_OP_STATUS 8'h70
`define NFC_OP_PSTAT 8'h78
`define NFC_OP_PSTATL 8'h75
`define NFC_OP_PROG 8'h80
`define NFC_OP_RNDIN 8'h85
`define NFC_OP_PGCONF 8'h10
`define NFC_OP_PLANESEP 8'h11
`define NFC_OP_CACHEPG 8'h15
`define NFC_OP_ERASE 8'h60
`define NFC_OP_ERCONF 8'hd0
`define NFC_OP_RESET 8'hff

// Address cycle counts
`define NFC_ADDR_FULL 3'h5
`define NFC_ADDR_ROW 3'h3
`define NFC_ADDR_COL 3'h2
`define NFC_ADDR_ID 3'h1

// Strobe half period in CLK cycles: 16 ns cycle at 4 ns per CLK
`define NFC_STROBE_NS 16
`define NFC_CLK_NS 4
`define NFC_HALF_CYC ((`NFC_STROBE_NS + 2 * `NFC_CLK_NS - 1) / (2 * `NFC_CLK_NS))

`endif

// ==== hdl/nfc_fifo.sv ====
`timescale 1ns/1ps
module nfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop, rdy_q, rdy_d;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
		rdy_d = (cnt_d != DEPTH[AW:0]);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
		end else if (ce) begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end

	// Storage needs no reset; only pointers carry meaning
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wp_q] <= in_data;
		end
	end

	assign in_ready = rdy_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
endmodule

// ==== hdl/nfc_host.sv ====
`timescale 1ns/1ps
// Contract
// (R1) Command: CLE high ALE low; address: ALE high CLE low; five cycles full.
// (R2) Data out: latches low, WE high, read strobe toggled; one byte per pulse.
// (R3) Write protect low makes device refuse program and erase.
// (R4) Chip select high while ready gives standby; ignored while busy.
// (R5) Page read 00h, five addresses, 30h; 35h for copy-back; multi-plane uses 60h.
// (R6) Random data out: 05h, two column addresses, E0h.
// (R7) Random data in: 85h, two column addresses, then data. Host op_info gives 85h the five-cycle address count.
// (R8) Random data in/out stays within the page already selected.
// (R9) Program: 80h, five addresses, data, 10h; device goes busy.
// (R10) Cache program start: 80h, five addresses, data, 15h.
// (R11) Multi-plane program ends first plane with 11h-81h; only status or reset between. Host accepts 80h or 85h after 11h, and flags 81h illegal.
// (R12) Copy-back program: 85h, five addresses, optional data, 10h.
// (R13) Erase: 60h, three row addresses, D0h; multi-plane repeats 60h first.
// (R14) While busy device accepts only reset, 70h, 78h plus three addresses, 75h.
// (R15) During read busy host holds both strobes high.
// (R16) Multi-plane random out only after multi-plane read.
// (R17) Multi-plane planes always in the same address order.
// (R18) Cache operations stay within one block.
// (R19) Cache read continue 31h, end 3Fh; enhanced adds 00h, five addresses first.
// (R20) Multi-plane cache read first step confirms with 30h or 33h.
// (R21) Host issues no opcode outside the command set.
// (R22) Multi-plane reads only on multi-plane programmed pages.
// (R23) Read ID: 90h, one address cycle, then ID bytes per read strobe.
module nfc_host
	import nfc_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CLK_EN,
	// Operation request
	input wire logic OP_VALID,
	output logic OP_READY,
	input wire nfc_pkg::nfc_kind_e OP_KIND,
	input wire nfc_pkg::nfc_byte_t OP_BYTE,
	input wire logic OP_LAST,
	// Read data
	output logic RD_VALID,
	output nfc_pkg::nfc_byte_t RD_DATA,
	output logic BUSY_SEEN,
	output logic ILLEGAL,
	// Flash pins
	output logic CHIP_SEL_N,
	output logic CMD_LATCH,
	output logic ADDR_LATCH,
	output logic WRITE_STROBE_N,
	output logic READ_STROBE_N,
	output logic WRITE_PROT_N,
	input wire logic [7:0] IO_IN,
	output logic [7:0] IO_OUT,
	output logic IO_OE_N,
	input wire logic READY_BUSY_N,
	// Control
	input wire logic WP_ALLOW
);
	import nfc_pkg::*;
	`include "nfc_defs.svh"

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_LOW = 3'h2,
		ST_HIGH = 3'h3,
		ST_WAIT = 3'h4
	} nfc_state_e;

	localparam logic [3:0] HALF = 4'(`NFC_HALF_CYC);

	logic f_valid, f_ready, f_last;
	nfc_kind_e f_kind;
	nfc_byte_t f_byte;
	logic [11:0] f_word;
	logic rb_sync;
	logic [7:0] io_s1_q, io_s2_q;

	nfc_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo ( // (R8) (R16) (R17) (R18) (R22)
		.clk(CLK),
		.rst(RESET),
		.ce(CLK_EN),
		.in_valid(OP_VALID),
		.in_ready(OP_READY),
		.in_data({OP_LAST, OP_KIND, OP_BYTE}),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_word)
	);
	assign f_last = f_word[11];
	assign f_kind = nfc_kind_e'(f_word[10:8]);
	assign f_byte = f_word[7:0];

	nfc_sync u_rb (
		.clk(CLK),
		.rst(RESET),
		.ce(CLK_EN),
		.din(READY_BUSY_N),
		.dout(rb_sync)
	);

	// Bus input sampled twice; data is stable well before the strobe rises
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
		end else if (CLK_EN) begin
			io_s1_q <= IO_IN;
			io_s2_q <= io_s1_q;
		end
	end

	nfc_state_e st_q, st_d;
	nfc_kind_e kind_q, kind_d;
	nfc_byte_t byte_q, byte_d;
	logic last_q, last_d;
	logic [3:0] tmr_q, tmr_d;
	logic [2:0] acnt_q, acnt_d;
	logic [2:0] aexp_q, aexp_d;
	logic rbusy_q, rbusy_d;
	logic cs_n_q, cs_n_d, cle_q, cle_d, ale_q, ale_d;
	logic we_n_q, we_n_d, re_n_q, re_n_d, oe_n_q, oe_n_d;
	nfc_byte_t io_q, io_d, rd_q, rd_d;
	logic rdv_q, rdv_d, busy_q, busy_d, ill_q, ill_d, wp_n_q, wp_n_d;
	logic legal_op, sep_q, sep_d;
	logic [3:0] info;

	// Opcode legality and the address count that follows it
	function automatic logic [3:0] op_info(input nfc_byte_t op);
		case (op)
			`NFC_OP_READ, `NFC_OP_PROG: op_info = {1'b1, `NFC_ADDR_FULL}; // (R5) (R9) (R10)
			`NFC_OP_RNDOUT: op_info = {1'b1, `NFC_ADDR_COL}; // (R6)
			`NFC_OP_ERASE, `NFC_OP_PSTAT: op_info = {1'b1, `NFC_ADDR_ROW}; // (R13) (R14)
			`NFC_OP_READID: op_info = {1'b1, `NFC_ADDR_ID}; // (R23)
			`NFC_OP_RNDIN: op_info = {1'b1, `NFC_ADDR_FULL}; // (R7) (R12)
			`NFC_OP_RDCONF, `NFC_OP_CBRD, `NFC_OP_MPCACHE, `NFC_OP_RNDOUTC,
			`NFC_OP_CACHERD, `NFC_OP_CACHEEND, `NFC_OP_STATUS, `NFC_OP_PSTATL,
			`NFC_OP_PGCONF, `NFC_OP_PLANESEP, `NFC_OP_CACHEPG, `NFC_OP_ERCONF,
			`NFC_OP_RESET: op_info = 4'h8; // (R19) (R20)
			default: op_info = 4'h0;
		endcase
	endfunction

	// Commands the device takes while busy
	function automatic logic busy_ok(input nfc_byte_t op);
		busy_ok = (op == `NFC_OP_RESET) || (op == `NFC_OP_STATUS) ||
			(op == `NFC_OP_PSTAT) || (op == `NFC_OP_PSTATL); // (R14)
	endfunction

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		last_d = last_q;
		tmr_d = tmr_q;
		acnt_d = acnt_q;
		aexp_d = aexp_q;
		rbusy_d = rbusy_q;
		cs_n_d = cs_n_q;
		cle_d = cle_q;
		ale_d = ale_q;
		we_n_d = we_n_q;
		re_n_d = re_n_q;
		oe_n_d = oe_n_q;
		io_d = io_q;
		rd_d = rd_q;
		rdv_d = 1'b0;
		busy_d = !rb_sync;
		ill_d = 1'b0;
		wp_n_d = WP_ALLOW; // (R3)
		f_ready = 1'b0;
		byte_d = byte_q;
		legal_op = 1'b1;
		sep_d = sep_q;
		info = op_info(f_byte);
		if (f_valid && f_kind == NFC_OP_CMD) begin
			legal_op = info[3]; // (R21)
			if (!rb_sync && !busy_ok(f_byte)) begin
				legal_op = 1'b0; // (R14)
			end
			if (sep_q && !busy_ok(f_byte) &&
				f_byte != `NFC_OP_PROG && f_byte != `NFC_OP_RNDIN) begin
				legal_op = 1'b0; // (R11)
			end
		end
		case (st_q)
			ST_IDLE: begin
				if (f_valid) begin
					f_ready = 1'b1;
					if (!legal_op) begin
						ill_d = 1'b1;
					end else begin
						st_d = ST_SETUP;
						kind_d = f_kind;
						byte_d = f_byte;
						last_d = f_last;
						tmr_d = HALF;
						cs_n_d = 1'b0;
						cle_d = (f_kind == NFC_OP_CMD); // (R1)
						ale_d = (f_kind == NFC_OP_ADDR); // (R1)
						oe_n_d = (f_kind == NFC_OP_DOUT) || (f_kind == NFC_OP_WAIT);
						io_d = f_byte;
						if (f_kind == NFC_OP_CMD) begin
							acnt_d = 3'h0;
							aexp_d = info[2:0];
							sep_d = (f_byte == `NFC_OP_PLANESEP) || // (R11) (R12)
								(sep_q && busy_ok(f_byte) && f_byte != `NFC_OP_RESET);
						end
						if (f_kind == NFC_OP_ADDR && acnt_q != aexp_q) begin
							acnt_d = acnt_q + 3'h1; // (R1)
						end
						if (f_kind == NFC_OP_WAIT) begin
							st_d = ST_WAIT;
						end
					end
				end else if (rb_sync) begin
					cs_n_d = 1'b1; // (R4)
				end
			end
			ST_SETUP: begin
				tmr_d = HALF;
				st_d = ST_LOW;
				if (kind_q == NFC_OP_DOUT) begin
					re_n_d = 1'b0; // (R2)
				end else begin
					we_n_d = 1'b0;
				end
			end
			ST_LOW: begin
				if (tmr_q != 4'h0) begin
					tmr_d = tmr_q - 4'h1;
				end else begin
					if (kind_q == NFC_OP_DOUT) begin
						rd_d = io_s2_q; // (R2) (R23)
						rdv_d = 1'b1;
					end
					we_n_d = 1'b1;
					re_n_d = 1'b1;
					tmr_d = HALF;
					st_d = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (tmr_q != 4'h0) begin
					tmr_d = tmr_q - 4'h1;
				end else begin
					cle_d = 1'b0;
					ale_d = 1'b0;
					oe_n_d = 1'b1;
					if (last_q) begin
						cs_n_d = 1'b1;
					end
					// Any command but reset and the status reads may start array work; flag it in rbusy
					rbusy_d = (kind_q == NFC_OP_CMD) && !busy_ok(byte_q);
					st_d = ST_IDLE;
				end
			end
			ST_WAIT: begin
				// Both strobes stay high until ready returns
				if (tmr_q != 4'h0) begin
					tmr_d = tmr_q - 4'h1;
				end else if (rb_sync) begin // (R15)
					rbusy_d = 1'b0;
					if (last_q) begin
						cs_n_d = 1'b1;
					end
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			st_q <= ST_IDLE;
			kind_q <= NFC_OP_CMD;
			byte_q <= 8'h00;
			last_q <= 1'b0;
			tmr_q <= 4'h0;
			acnt_q <= 3'h0;
			aexp_q <= 3'h0;
			rbusy_q <= 1'b0;
			cs_n_q <= 1'b1;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			io_q <= 8'h00;
			rd_q <= 8'h00;
			rdv_q <= 1'b0;
			busy_q <= 1'b0;
			ill_q <= 1'b0;
			wp_n_q <= 1'b0;
			sep_q <= 1'b0;
		end else if (CLK_EN) begin
			st_q <= st_d;
			kind_q <= kind_d;
			byte_q <= byte_d;
			last_q <= last_d;
			tmr_q <= tmr_d;
			acnt_q <= acnt_d;
			aexp_q <= aexp_d;
			rbusy_q <= rbusy_d;
			cs_n_q <= cs_n_d;
			cle_q <= cle_d;
			ale_q <= ale_d;
			we_n_q <= we_n_d;
			re_n_q <= re_n_d;
			oe_n_q <= oe_n_d;
			io_q <= io_d;
			rd_q <= rd_d;
			rdv_q <= rdv_d;
			busy_q <= busy_d;
			ill_q <= ill_d;
			wp_n_q <= wp_n_d;
			sep_q <= sep_d;
		end
	end

	assign CHIP_SEL_N = cs_n_q;
	assign CMD_LATCH = cle_q;
	assign ADDR_LATCH = ale_q;
	assign WRITE_STROBE_N = we_n_q;
	assign READ_STROBE_N = re_n_q;
	assign WRITE_PROT_N = wp_n_q;
	assign IO_OUT = io_q;
	assign IO_OE_N = oe_n_q;
	assign RD_VALID = rdv_q;
	assign RD_DATA = rd_q;
	assign BUSY_SEEN = busy_q;
	assign ILLEGAL = ill_q;
endmodule

// ==== hdl/nfc_pkg.sv ====
package nfc_pkg;
	typedef enum logic [2:0] {
		NFC_OP_CMD = 3'h0,
		NFC_OP_ADDR = 3'h1,
		NFC_OP_DIN = 3'h2,
		NFC_OP_DOUT = 3'h3,
		NFC_OP_WAIT = 3'h4
	} nfc_kind_e;
	typedef logic [7:0] nfc_byte_t;
endpackage

// ==== hdl/nfc_sync.sv ====
`timescale 1ns/1ps
module nfc_sync (
	// Clock
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Level
	input wire logic din,
	output logic dout
);
	logic s1_q, s2_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// Resets to the ready level so no false busy follows reset
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
		end
	end

	assign dout = s2_q;
endmodule

// ==== tb/nfc_dev.sv ====
`timescale 1ns/1ps
module nfc_dev #(
	parameter logic [7:0] ID_BASE = 8'h5a, // Arbitrary
	parameter int BUSY_NS = 2000
) (
	// Flash pins
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io,
	// Device drive
	output logic [7:0] dq,
	output logic rb_n
);
	logic [7:0] cmd = 8'h00;
	logic [7:0] col = 8'h00;
	logic [7:0] cnt = 8'h00;
	logic [7:0] last = 8'h00;
	logic busy = 1'b0;
	int na = 0;
	assign rb_n = !busy;
	// Released bus shows the inverse so a stale byte never passes
	assign dq = re_n ? ~last : last;
	always @(posedge we_n) begin
		if (!ce_n && cle && (!busy || io inside {8'h70, 8'h75, 8'h78, 8'hff})) begin
			cmd = io;
			na = 0;
			cnt = 8'h00;
			if (io inside {8'h30, 8'h33, 8'h35} ||
				(wp_n && io inside {8'h10, 8'h15, 8'hd0}))
				busy = 1'b1;
		end
		if (!ce_n && ale && !busy) begin
			if (na == 0)
				col = io;
			na++;
		end
	end
	always @(posedge busy) #BUSY_NS busy = 1'b0;
	always @(negedge re_n) begin
		if (!ce_n) begin
			if (cmd == 8'h90)
				last = ID_BASE + cnt;
			else if (cmd == 8'h70)
				last = busy ? 8'ha0 : 8'he0;
			else
				last = col + cnt;
		end
	end
	always @(posedge re_n) if (!ce_n) cnt++;
endmodule

// ==== tb/nfc_host_sva.sv ====
`timescale 1ns/1ps
module nfc_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Watched
	input wire logic WP_ALLOW,
	input wire logic RD_VALID,
	input wire logic ILLEGAL,
	input wire logic CHIP_SEL_N,
	input wire logic CMD_LATCH,
	input wire logic ADDR_LATCH,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic WRITE_PROT_N,
	input wire logic IO_OE_N
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	chk_latch_excl: assert property (CMD_LATCH |-> !ADDR_LATCH)
		else $error("both latches high");
	chk_strobe_sel: assert property (!WRITE_STROBE_N || !READ_STROBE_N |-> !CHIP_SEL_N)
		else $error("strobe while deselected");
	chk_write_drive: assert property (!WRITE_STROBE_N |-> !IO_OE_N)
		else $error("write strobe without bus drive");
	chk_we_width: assert property ($fell(WRITE_STROBE_N) |->
		!WRITE_STROBE_N [*3] ##1 WRITE_STROBE_N)
		else $error("write strobe width");
	chk_dout_mode: assert property (!READ_STROBE_N |->
		!CMD_LATCH && !ADDR_LATCH && IO_OE_N && WRITE_STROBE_N)
		else $error("bad read cycle");
	chk_rd_byte: assert property ($rose(READ_STROBE_N) |-> ##[0:2] RD_VALID)
		else $error("read byte missing");
	chk_wp_copy: assert property (!$past(RESET) |-> WRITE_PROT_N == $past(WP_ALLOW))
		else $error("protect pin lags");
	chk_drop_quiet: assert property (ILLEGAL |-> WRITE_STROBE_N && READ_STROBE_N)
		else $error("dropped command strobed");
	cover property (ILLEGAL);
	cover property (RD_VALID);
	cover property ($fell(WRITE_STROBE_N) && CMD_LATCH);
endmodule

// ==== tb/test_nfc_host.sv ====
`timescale 1ns/1ps
module test_nfc_host;
	import nfc_pkg::*;
	localparam logic [7:0] ID_B = 8'h5a;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic CLK_EN = 1'b1;
	logic OP_VALID = 1'b0;
	logic OP_LAST = 1'b0;
	logic WP_ALLOW = 1'b1;
	nfc_kind_e OP_KIND = NFC_OP_CMD;
	nfc_byte_t OP_BYTE = 8'h00;
	nfc_byte_t RD_DATA;
	logic OP_READY, RD_VALID, BUSY_SEEN, ILLEGAL, CHIP_SEL_N, CMD_LATCH, ADDR_LATCH;
	logic WRITE_STROBE_N, READ_STROBE_N, WRITE_PROT_N, IO_OE_N, READY_BUSY_N;
	logic [7:0] IO_IN, IO_OUT, dq;
	int n_mismatch = 0;
	int check_count = 0;
	int n_ill = 0;
	int n_busy = 0;
	int n_full = 0;
	int cyc = 0;
	assign IO_IN = IO_OE_N ? dq : IO_OUT;
	nfc_host i_dut (.CLK(CLK), .RESET(RESET), .CLK_EN(CLK_EN), .OP_VALID(OP_VALID),
		.OP_READY(OP_READY), .OP_KIND(OP_KIND), .OP_BYTE(OP_BYTE), .OP_LAST(OP_LAST),
		.RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .BUSY_SEEN(BUSY_SEEN), .ILLEGAL(ILLEGAL),
		.CHIP_SEL_N(CHIP_SEL_N), .CMD_LATCH(CMD_LATCH), .ADDR_LATCH(ADDR_LATCH),
		.WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
		.WRITE_PROT_N(WRITE_PROT_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N),
		.READY_BUSY_N(READY_BUSY_N), .WP_ALLOW(WP_ALLOW));
	nfc_dev #(.ID_BASE(ID_B)) i_dev (.ce_n(CHIP_SEL_N), .cle(CMD_LATCH), .ale(ADDR_LATCH),
		.we_n(WRITE_STROBE_N), .re_n(READ_STROBE_N), .wp_n(WRITE_PROT_N), .io(IO_IN),
		.dq(dq), .rb_n(READY_BUSY_N));
	initial forever #2 CLK = ~CLK;
	always @(negedge READY_BUSY_N) n_busy++;
	always @(negedge CLK) begin
		cyc++;
		if (ILLEGAL === 1'b1)
			n_ill++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Valid stays up between ops so no edge sees it drop and rise at once
	task automatic op(input nfc_kind_e k, input nfc_byte_t b, input logic l = 1'b0);
		OP_VALID = 1'b1;
		OP_KIND = k;
		OP_BYTE = b;
		OP_LAST = l;
		while (OP_READY !== 1'b1) begin
			n_full++;
			@(negedge CLK);
		end
		@(negedge CLK);
	endtask
	task automatic rd(input logic w = 1'b1);
		if (w)
			op(NFC_OP_WAIT, 8'h00);
		op(NFC_OP_DOUT, 8'h00, 1'b1);
		OP_VALID = 1'b0;
		for (int i = 0; i < 3000 && RD_VALID !== 1'b1; i++) @(negedge CLK);
		chk(8'(RD_VALID), 8'h01);
	endtask
	task automatic prog();
		op(NFC_OP_WAIT, 8'h00);
		op(NFC_OP_CMD, 8'h80);
		for (int i = 0; i < 5; i++) op(NFC_OP_ADDR, 8'h00);
		op(NFC_OP_DIN, 8'h3c);
		op(NFC_OP_CMD, 8'h10);
		op(NFC_OP_CMD, 8'h70);
		rd();
	endtask
	task automatic t_id();
		op(NFC_OP_CMD, 8'h90);
		op(NFC_OP_ADDR, 8'h00);
		rd();
		chk(RD_DATA, ID_B);
		rd();
		chk(RD_DATA, ID_B + 8'h01);
		$display("test id done");
	endtask
	task automatic t_read();
		op(NFC_OP_CMD, 8'h00);
		op(NFC_OP_ADDR, 8'h03);
		for (int i = 0; i < 4; i++) op(NFC_OP_ADDR, 8'h00);
		op(NFC_OP_CMD, 8'h30);
		rd();
		chk(RD_DATA, 8'h03);
		op(NFC_OP_CMD, 8'h05);
		op(NFC_OP_ADDR, 8'h07);
		op(NFC_OP_ADDR, 8'h00);
		op(NFC_OP_CMD, 8'he0);
		rd();
		chk(RD_DATA, 8'h07);
		$display("test read done");
	endtask
	task automatic t_bad();
		op(NFC_OP_CMD, 8'h42);
		op(NFC_OP_CMD, 8'h11);
		op(NFC_OP_CMD, 8'h30);
		op(NFC_OP_CMD, 8'h80);
		op(NFC_OP_CMD, 8'h60);
		for (int i = 0; i < 3; i++) op(NFC_OP_ADDR, 8'h01);
		op(NFC_OP_CMD, 8'hd0);
		OP_VALID = 1'b0;
		for (int i = 0; i < 200 && BUSY_SEEN !== 1'b1; i++) @(negedge CLK);
		chk(8'(BUSY_SEEN), 8'h01);
		op(NFC_OP_CMD, 8'h00);
		op(NFC_OP_CMD, 8'h70);
		rd(1'b0);
		chk(RD_DATA, 8'ha0);
		chk(8'(n_ill), 8'h03);
		$display("test bad done");
	endtask
	task automatic t_wp();
		int nb;
		nb = n_busy;
		WP_ALLOW = 1'b0;
		prog();
		chk(8'(n_busy - nb), 8'h00);
		WP_ALLOW = 1'b1;
		prog();
		chk(8'(n_busy - nb), 8'h01);
		chk(RD_DATA, 8'he0);
		$display("test wp done");
	endtask
	task automatic t_fifo();
		n_full = 0;
		for (int i = 0; i < 24; i++) op(NFC_OP_CMD, 8'h70);
		rd();
		chk(8'(n_full != 0), 8'h01);
		chk(RD_DATA, 8'he0);
		$display("test fifo done");
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		RESET = 1'b0;
		t_id();
		t_read();
		t_bad();
		t_wp();
		t_fifo();
		summarize();
	end
endmodule
bind nfc_host nfc_chk i_chk (.CLK(CLK), .RESET(RESET), .WP_ALLOW(WP_ALLOW),
	.RD_VALID(RD_VALID), .ILLEGAL(ILLEGAL), .CHIP_SEL_N(CHIP_SEL_N), .CMD_LATCH(CMD_LATCH),
	.ADDR_LATCH(ADDR_LATCH), .WRITE_STROBE_N(WRITE_STROBE_N),
	.READ_STROBE_N(READ_STROBE_N), .WRITE_PROT_N(WRITE_PROT_N), .IO_OE_N(IO_OE_N));
